// ---- logic/adcctl_pkg.sv ----
// constants, register map and types shared by the converter control block
// assumes a single 100 MHz clock; all slower rates are enable pulses
package adcctl_pkg;

	// ***************************************************
	// clock and timing
	// ***************************************************
	localparam int unsigned CLK_PERIOD_NS      = 10;
	localparam int unsigned ONE_KHZ_PERIOD_NS  = 1000000;
	localparam int unsigned ONE_KHZ_CYCLES     =
		ONE_KHZ_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned LOCAL_ASYNC_DIV    = 4;
	localparam int unsigned CONV_TICKS         = 20;
	localparam int unsigned RESULT_W           = 10;
	localparam int unsigned EXT_PINS           = 16;

	// ***************************************************
	// register byte offsets
	// ***************************************************
	localparam logic [7:0] OFF_STATUS_CTRL_ONE = 8'h00;
	localparam logic [7:0] OFF_CONFIG          = 8'h04;
	localparam logic [7:0] OFF_PIN_EN_ONE      = 8'h08;
	localparam logic [7:0] OFF_PIN_EN_TWO      = 8'h0c;
	localparam logic [7:0] OFF_WAKEUP_CTRL     = 8'h10;
	localparam logic [7:0] OFF_RESULT          = 8'h14;
	localparam logic [7:0] OFF_STATE           = 8'h18;

	// ***************************************************
	// field positions and reset values
	// ***************************************************
	localparam int unsigned SC_DONE_BIT        = 7;
	localparam int unsigned SC_CONT_BIT        = 5;
	localparam int unsigned CFG_HWTRIG_BIT     = 2;
	localparam int unsigned CFG_DIV_LSB        = 5;
	localparam int unsigned WK_SRC_BIT         = 3;
	localparam logic [4:0] CHAN_RESET          = 5'h1f;
	localparam logic [1:0] CLKSRC_RESET        = 2'h0;
	localparam logic [1:0] DIV_RESET           = 2'h0;
	localparam logic [2:0] WK_PERIOD_RESET     = 3'h0;

	// ***************************************************
	// channel select codes
	// ***************************************************
	localparam logic [4:0] CH_EXT_LAST         = 5'h0f;
	localparam logic [4:0] CH_UNIMP_FIRST      = 5'h10;
	localparam logic [4:0] CH_UNIMP_LAST       = 5'h15;
	localparam logic [4:0] CH_RSV_FIRST        = 5'h16;
	localparam logic [4:0] CH_RSV_LAST         = 5'h19;
	localparam logic [4:0] CH_TEMP             = 5'h1a;
	localparam logic [4:0] CH_BANDGAP          = 5'h1b;
	localparam logic [4:0] CH_RSV_HIGH         = 5'h1c;
	localparam logic [4:0] CH_VREFH            = 5'h1d;
	localparam logic [4:0] CH_VREFL            = 5'h1e;
	localparam logic [4:0] CH_OFF              = 5'h1f;

	typedef enum logic [1:0] {
		ADCCTL_SRC_BUS,
		ADCCTL_SRC_BUS_HALF,
		ADCCTL_SRC_ALT,
		ADCCTL_SRC_LOCAL
	} adcctl_clk_src_t;

endpackage

// ---- logic/adcctl_wakeup.sv ----
// periodic wakeup counter producing the hardware conversion trigger
// assumes tick inputs are one-cycle enables in the clk_in domain
module adcctl_wakeup (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic       tick_1khz_in,
	input  wire logic       tick_ext_in,
	input  wire logic       src_ext_in,
	input  wire logic [2:0] period_sel_in,
	input  wire logic       stop_in,
	output logic            trigger_out
);

	// ***************************************************
	// counter
	// ***************************************************
	logic [15:0] count_r;
	logic        level_r;
	logic        level_d_r;
	logic        tick;
	logic        wrap;

	// the external reference stops in partial-power stop; 1 kHz keeps going
	assign tick = src_ext_in ? (tick_ext_in & ~stop_in) : tick_1khz_in;
	// select 0 holds the counter off; others give 2^(2*sel+2) ticks
	assign wrap = (count_r ==
		16'((32'h1 << (2 * period_sel_in + 2)) - 1));

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			count_r <= 16'h0000;
		end else if (period_sel_in == 3'h0) begin
			count_r <= 16'h0000;
		end else if (tick) begin
			count_r <= wrap ? 16'h0000 : count_r + 16'h0001;
		end
	end

	// ***************************************************
	// output level and rising-edge trigger
	// ***************************************************
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			level_r <= 1'b0;
		end else if (period_sel_in == 3'h0) begin
			level_r <= 1'b0;
		end else if (tick && wrap) begin
			level_r <= ~level_r;
		end
	end

	// only the rising edge fires: first overflow, then every second
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			level_d_r   <= 1'b0;
			trigger_out <= 1'b0;
		end else begin
			level_d_r   <= level_r;
			trigger_out <= level_r & ~level_d_r;
		end
	end

endmodule

// ---- logic/adcctl_top.sv ----
// converter control: channel routing, conversion clock, trigger, apb regs
// assumes all pins synchronous to clk_in; analog core outside this block
// ***************************************************
// how it works
// ***************************************************
module adcctl_top #(
	parameter int unsigned ONE_KHZ_CYCLES = adcctl_pkg::ONE_KHZ_CYCLES,
	parameter int unsigned CONV_TICKS     = adcctl_pkg::CONV_TICKS,
	parameter int unsigned RESULT_W       = adcctl_pkg::RESULT_W
) (
	input  wire logic                clk_in,
	input  wire logic                reset_in,
	input  wire logic                psel_in,
	input  wire logic                penable_in,
	input  wire logic                pwrite_in,
	input  wire logic [7:0]          paddr_in,
	input  wire logic [31:0]         pwdata_in,
	output logic      [31:0]         prdata_out,
	output logic                     pready_out,
	output logic                     pslverr_out,
	input  wire logic                ext_ref_clock_in,
	input  wire logic                wait_mode_in,
	input  wire logic                partial_power_stop_in,
	input  wire logic [RESULT_W-1:0] analog_result_in,
	output logic      [15:0]         pin_analog_en_out,
	output logic      [15:0]         ext_sel_out,
	output logic                     vrefl_sel_out,
	output logic                     vrefh_sel_out,
	output logic                     temp_sel_out,
	output logic                     bandgap_sel_out,
	output logic                     conv_power_out,
	output logic                     conv_busy_out,
	output logic                     conv_done_out
);

	// ***************************************************
	// declarations
	// ***************************************************
	typedef enum logic [1:0] {
		ADCCTL_OFF,
		ADCCTL_IDLE,
		ADCCTL_CONV
	} adcctl_state_t;

	adcctl_state_t              state_r;
	logic [4:0]                 chan_r;
	logic                       cont_r;
	logic                       done_r;
	logic                       hwtrig_en_r;
	logic [1:0]                 clk_src_r;
	logic [1:0]                 div_r;
	logic [7:0]                 pin_en_one_r;
	logic [7:0]                 pin_en_two_r;
	logic [2:0]                 wk_period_r;
	logic                       wk_src_ext_r;
	logic [RESULT_W-1:0]        result_r;
	logic                       ext_d_r;
	logic                       half_r;
	logic [1:0]                 local_cnt_r;
	logic [16:0]                khz_cnt_r;
	logic [2:0]                 div_cnt_r;
	logic [7:0]                 tick_cnt_r;
	logic                       trig_pend_r;
	logic                       ext_tick;
	logic                       khz_tick;
	logic                       src_tick;
	logic                       conv_tick;
	logic                       hw_trigger;
	logic                       wr_acc;
	logic                       sc_write;
	logic                       addr_ok;
	logic                       last_tick;

	// ***************************************************
	// channel decode and divide mask helpers
	// ***************************************************
	function automatic logic in_range(input logic [4:0] c,
		input logic [4:0] lo, input logic [4:0] hi);
		in_range = (c >= lo) && (c <= hi);
	endfunction

	function automatic logic [2:0] div_mask(input logic [1:0] d);
		div_mask = 3'(({1'b0, 3'h7} >> (2'd3 - d)));
	endfunction

	// ***************************************************
	// apb slave
	// ***************************************************
	assign wr_acc   = psel_in & penable_in & pready_out & pwrite_in;
	assign sc_write = wr_acc && (paddr_in == adcctl_pkg::OFF_STATUS_CTRL_ONE);

	always_comb begin
		unique case (paddr_in)
			adcctl_pkg::OFF_STATUS_CTRL_ONE,
			adcctl_pkg::OFF_CONFIG,
			adcctl_pkg::OFF_PIN_EN_ONE,
			adcctl_pkg::OFF_PIN_EN_TWO,
			adcctl_pkg::OFF_WAKEUP_CTRL,
			adcctl_pkg::OFF_RESULT,
			adcctl_pkg::OFF_STATE: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// no wait state: answer in the first access cycle, read data latched
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
		end else begin
			pready_out  <= psel_in & ~penable_in;
			pslverr_out <= psel_in & ~penable_in & ~addr_ok;
			if (psel_in && !penable_in && !pwrite_in) begin
				unique case (paddr_in)
					adcctl_pkg::OFF_STATUS_CTRL_ONE:
						prdata_out <= {24'h000000, done_r, 1'b0, cont_r,
							chan_r};
					adcctl_pkg::OFF_CONFIG:
						prdata_out <= {25'h0000000, div_r, 2'h0,
							hwtrig_en_r, clk_src_r};
					adcctl_pkg::OFF_PIN_EN_ONE:
						prdata_out <= {24'h000000, pin_en_one_r};
					adcctl_pkg::OFF_PIN_EN_TWO:
						prdata_out <= {24'h000000, pin_en_two_r};
					adcctl_pkg::OFF_WAKEUP_CTRL:
						prdata_out <= {28'h0000000, wk_src_ext_r,
							wk_period_r};
					adcctl_pkg::OFF_RESULT:
						prdata_out <= 32'(result_r);
					adcctl_pkg::OFF_STATE:
						prdata_out <= {28'h0000000, trig_pend_r,
							conv_power_out, 2'(state_r)};
					default:
						prdata_out <= 32'h0000_0000;
				endcase
			end else begin
				prdata_out <= 32'h0000_0000;
			end
		end
	end

	// ***************************************************
	// control registers
	// ***************************************************
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			chan_r <= adcctl_pkg::CHAN_RESET;
			cont_r <= 1'b0;
		end else if (sc_write) begin
			chan_r <= pwdata_in[4:0];
			cont_r <= pwdata_in[adcctl_pkg::SC_CONT_BIT];
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			hwtrig_en_r <= 1'b0;
			clk_src_r   <= adcctl_pkg::CLKSRC_RESET;
			div_r       <= adcctl_pkg::DIV_RESET;
		end else if (wr_acc && paddr_in == adcctl_pkg::OFF_CONFIG) begin
			hwtrig_en_r <= pwdata_in[adcctl_pkg::CFG_HWTRIG_BIT];
			clk_src_r   <= pwdata_in[1:0];
			div_r       <= pwdata_in[adcctl_pkg::CFG_DIV_LSB +: 2];
		end
	end

	// two pin enable registers, eight pins each
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pin_en_one_r <= 8'h00;
			pin_en_two_r <= 8'h00;
		end else if (wr_acc) begin
			if (paddr_in == adcctl_pkg::OFF_PIN_EN_ONE)
				pin_en_one_r <= pwdata_in[7:0];
			if (paddr_in == adcctl_pkg::OFF_PIN_EN_TWO)
				pin_en_two_r <= pwdata_in[7:0];
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			wk_period_r  <= adcctl_pkg::WK_PERIOD_RESET;
			wk_src_ext_r <= 1'b0;
		end else if (wr_acc &&
			paddr_in == adcctl_pkg::OFF_WAKEUP_CTRL) begin
			wk_period_r  <= pwdata_in[2:0];
			wk_src_ext_r <= pwdata_in[adcctl_pkg::WK_SRC_BIT];
		end
	end

	// ***************************************************
	// clock enables
	// ***************************************************
	// the reference pin is sampled, so it must be well below clk_in / 2
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ext_d_r     <= 1'b0;
			half_r      <= 1'b0;
			local_cnt_r <= 2'h0;
		end else begin
			ext_d_r     <= ext_ref_clock_in;
			half_r      <= ~half_r;
			local_cnt_r <= local_cnt_r + 2'h1;
		end
	end

	assign ext_tick = ext_ref_clock_in & ~ext_d_r;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			khz_cnt_r <= 17'h00000;
		end else if (khz_cnt_r == 17'(ONE_KHZ_CYCLES - 1)) begin
			khz_cnt_r <= 17'h00000;
		end else begin
			khz_cnt_r <= khz_cnt_r + 17'h00001;
		end
	end

	assign khz_tick = (khz_cnt_r == 17'(ONE_KHZ_CYCLES - 1));

	// wait mode gates nothing: the alternate clock runs on in wait
	always_comb begin
		unique case (adcctl_pkg::adcctl_clk_src_t'(clk_src_r))
			adcctl_pkg::ADCCTL_SRC_BUS:      src_tick = 1'b1;
			adcctl_pkg::ADCCTL_SRC_BUS_HALF: src_tick = half_r;
			adcctl_pkg::ADCCTL_SRC_ALT:
				src_tick = ext_tick & ~partial_power_stop_in;
			adcctl_pkg::ADCCTL_SRC_LOCAL:
				src_tick = (local_cnt_r ==
					2'(adcctl_pkg::LOCAL_ASYNC_DIV - 1));
		endcase
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			div_cnt_r <= 3'h0;
		end else if (src_tick) begin
			div_cnt_r <= (div_cnt_r & div_mask(div_r)) == div_mask(div_r)
				? 3'h0 : div_cnt_r + 3'h1;
		end
	end

	assign conv_tick = src_tick &&
		((div_cnt_r & div_mask(div_r)) == div_mask(div_r));

	// ***************************************************
	// hardware trigger
	// ***************************************************
	adcctl_wakeup u_wakeup (
		.clk_in        (clk_in),
		.reset_in      (reset_in),
		.tick_1khz_in  (khz_tick),
		.tick_ext_in   (ext_tick),
		.src_ext_in    (wk_src_ext_r),
		.period_sel_in (wk_period_r),
		.stop_in       (partial_power_stop_in),
		.trigger_out   (hw_trigger)
	);

	// a trigger waits for the conversion clock; set wins over consume
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			trig_pend_r <= 1'b0;
		end else if (hw_trigger && hwtrig_en_r) begin
			trig_pend_r <= 1'b1;
		end else if (conv_tick || sc_write || !hwtrig_en_r) begin
			trig_pend_r <= 1'b0;
		end
	end

	// ***************************************************
	// conversion sequencer
	// ***************************************************
	assign last_tick = conv_tick && (tick_cnt_r == 8'(CONV_TICKS - 1));

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_r    <= ADCCTL_OFF;
			tick_cnt_r <= 8'h00;
		end else if (sc_write) begin
			tick_cnt_r <= 8'h00;
			if (pwdata_in[4:0] == adcctl_pkg::CH_OFF)
				state_r <= ADCCTL_OFF;
			else if (hwtrig_en_r)
				state_r <= ADCCTL_IDLE;
			else
				state_r <= ADCCTL_CONV;
		end else begin
			unique case (state_r)
				ADCCTL_OFF: begin
					tick_cnt_r <= 8'h00;
				end
				ADCCTL_IDLE: begin
					tick_cnt_r <= 8'h00;
					if (trig_pend_r && conv_tick)
						state_r <= ADCCTL_CONV;
				end
				ADCCTL_CONV: begin
					if (last_tick) begin
						tick_cnt_r <= 8'h00;
						if (!cont_r)
							state_r <= ADCCTL_IDLE;
					end else if (conv_tick) begin
						tick_cnt_r <= tick_cnt_r + 8'h01;
					end
				end
			endcase
		end
	end

	// unimplemented codes sit on the low reference, so they read as zero
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			result_r <= '0;
		end else if (state_r == ADCCTL_CONV && last_tick && !sc_write) begin
			if (in_range(chan_r, adcctl_pkg::CH_UNIMP_FIRST,
				adcctl_pkg::CH_UNIMP_LAST))
				result_r <= '0;
			else
				result_r <= analog_result_in;
		end
	end

	// a clearing write wins over completion in the same cycle
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			done_r <= 1'b0;
		end else if (state_r == ADCCTL_CONV && last_tick && !sc_write) begin
			done_r <= 1'b1;
		end else if (sc_write) begin
			done_r <= 1'b0;
		end
	end

	// ***************************************************
	// analog routing outputs
	// ***************************************************
	// only 20 inputs are wired; reserved codes select nothing
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ext_sel_out     <= 16'h0000;
			vrefl_sel_out   <= 1'b0;
			vrefh_sel_out   <= 1'b0;
			temp_sel_out    <= 1'b0;
			bandgap_sel_out <= 1'b0;
			conv_power_out  <= 1'b0;
		end else begin
			ext_sel_out     <= (chan_r <= adcctl_pkg::CH_EXT_LAST)
				? 16'(16'h0001 << chan_r[3:0]) : 16'h0000;
			vrefl_sel_out   <= in_range(chan_r, adcctl_pkg::CH_UNIMP_FIRST,
				adcctl_pkg::CH_UNIMP_LAST) ||
				chan_r == adcctl_pkg::CH_VREFL;
			vrefh_sel_out   <= chan_r == adcctl_pkg::CH_VREFH;
			temp_sel_out    <= chan_r == adcctl_pkg::CH_TEMP;
			// bandgap buffer is enabled by software elsewhere first
			bandgap_sel_out <= chan_r == adcctl_pkg::CH_BANDGAP;
			conv_power_out  <= chan_r != adcctl_pkg::CH_OFF;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pin_analog_en_out <= 16'h0000;
			conv_busy_out     <= 1'b0;
			conv_done_out     <= 1'b0;
		end else begin
			pin_analog_en_out <= {pin_en_two_r, pin_en_one_r};
			conv_busy_out     <= state_r == ADCCTL_CONV;
			conv_done_out     <= done_r;
		end
	end

endmodule

// ---- verif/adcctl_top_sva.sv ----
// checker for the converter control block, attached by bind
// sees only top ports; one clock, asynchronous active-high reset
module adcctl_top_chk #(
	parameter int unsigned ONE_KHZ_CYCLES = 20,
	parameter int unsigned CONV_TICKS     = 4,
	parameter int unsigned RESULT_W       = 10
) (
	input wire logic                clk_in,
	input wire logic                reset_in,
	input wire logic                psel_in,
	input wire logic                penable_in,
	input wire logic                pwrite_in,
	input wire logic [7:0]          paddr_in,
	input wire logic [31:0]         pwdata_in,
	input wire logic [31:0]         prdata_out,
	input wire logic                pready_out,
	input wire logic                pslverr_out,
	input wire logic                ext_ref_clock_in,
	input wire logic                wait_mode_in,
	input wire logic                partial_power_stop_in,
	input wire logic [RESULT_W-1:0] analog_result_in,
	input wire logic [15:0]         pin_analog_en_out,
	input wire logic [15:0]         ext_sel_out,
	input wire logic                vrefl_sel_out,
	input wire logic                vrefh_sel_out,
	input wire logic                temp_sel_out,
	input wire logic                bandgap_sel_out,
	input wire logic                conv_power_out,
	input wire logic                conv_busy_out,
	input wire logic                conv_done_out
);
	// ****
	// helpers
	// ****
	logic       wr_ok;
	logic       wr_sc;
	logic [7:0] wd_r;
	assign wr_ok = psel_in & penable_in & pready_out & pwrite_in;
	assign wr_sc = wr_ok && paddr_in == adcctl_pkg::OFF_STATUS_CTRL_ONE;
	// written byte kept so checks two cycles on see it
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			wd_r <= 8'h00;
		else if (wr_ok)
			wd_r <= pwdata_in[7:0];
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// ****
	// assertions
	// ****
	ext_route_a: assert property (wr_sc && !pwdata_in[4] |-> ##2
		ext_sel_out == (16'h1 << wd_r[3:0])) else $error("ext select");
	low_ref_a: assert property (wr_sc && pwdata_in[4:0] inside
		{[5'h10:5'h15]} |-> ##2 vrefl_sel_out && ext_sel_out == 16'h0)
		else $error("low ref select");
	rsv_quiet_a: assert property (wr_sc && pwdata_in[4:0] inside
		{[5'h16:5'h19], 5'h1c} |-> ##2 {vrefl_sel_out, vrefh_sel_out,
		temp_sel_out, bandgap_sel_out, ext_sel_out} == 20'h0)
		else $error("reserved select");
	temp_route_a: assert property (wr_sc && pwdata_in[4:0] == 5'h1a
		|-> ##2 temp_sel_out && !bandgap_sel_out) else $error("temp");
	gap_route_a: assert property (wr_sc && pwdata_in[4:0] == 5'h1b
		|-> ##2 bandgap_sel_out && !temp_sel_out) else $error("gap");
	off_write_a: assert property (wr_sc && pwdata_in[4:0] == 5'h1f
		|-> ##2 !conv_power_out && !conv_busy_out) else $error("off");
	off_isolate_a: assert property (!conv_power_out |->
		ext_sel_out == 16'h0 && !vrefl_sel_out && !temp_sel_out)
		else $error("inputs not isolated");
	busy_power_a: assert property (conv_busy_out |-> conv_power_out)
		else $error("busy while off");
	write_clr_a: assert property (wr_sc |-> ##2 !conv_done_out)
		else $error("done not cleared");
	pin_en_a: assert property (wr_ok && paddr_in ==
		adcctl_pkg::OFF_PIN_EN_ONE |-> ##2 pin_analog_en_out[7:0] == wd_r)
		else $error("pin enable");
	cover property (wr_sc ##[1:500] conv_done_out);
	cover property (conv_busy_out && temp_sel_out);
	cover property ($rose(conv_done_out) && !conv_busy_out);
endmodule

bind adcctl_top adcctl_top_chk #(
	.ONE_KHZ_CYCLES(ONE_KHZ_CYCLES),
	.CONV_TICKS    (CONV_TICKS),
	.RESULT_W      (RESULT_W)
) u_chk (.*);

// ---- verif/tb_adcctl_top.sv ----
// self-checking bench for the converter control block
// drives apb and pins at rising edges; checker joins by bind
module tb_adcctl_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] SC = adcctl_pkg::OFF_STATUS_CTRL_ONE;
	localparam logic [7:0] CF = adcctl_pkg::OFF_CONFIG;
	localparam logic [7:0] P1 = adcctl_pkg::OFF_PIN_EN_ONE;
	localparam logic [7:0] P2 = adcctl_pkg::OFF_PIN_EN_TWO;
	localparam logic [7:0] WK = adcctl_pkg::OFF_WAKEUP_CTRL;
	localparam logic [7:0] RS = adcctl_pkg::OFF_RESULT;
	localparam logic [7:0] ST = adcctl_pkg::OFF_STATE;
	logic        clk_in, reset_in, psel_in, penable_in, pwrite_in, rerr;
	logic [7:0]  paddr_in;
	logic [31:0] pwdata_in, prdata_out, rdat;
	logic        pready_out, pslverr_out, ext_ref_clock_in, wait_mode_in;
	logic        partial_power_stop_in, vrefl_sel_out, vrefh_sel_out;
	logic        temp_sel_out, bandgap_sel_out, conv_power_out;
	logic        conv_busy_out, conv_done_out;
	logic [9:0]  analog_result_in;
	logic [15:0] pin_analog_en_out, ext_sel_out;
	logic [20:0] sel_obs;
	logic [1:0]  eref_cnt;
	int          n_mismatch, cmp_count, cyc, waited;

	// short counts keep the wakeup and conversion runs brief
	adcctl_top #(.ONE_KHZ_CYCLES(20), .CONV_TICKS(4)) dut (.*);
	assign sel_obs = {ext_sel_out, vrefl_sel_out, vrefh_sel_out,
		temp_sel_out, bandgap_sel_out, conv_power_out};

	always #5 clk_in = ~clk_in;
	// external reference at one sixth of the bus rate
	// runs freely, as an enabled external source in high range would
	always @(posedge clk_in) begin
		eref_cnt <= (eref_cnt == 2'h2) ? 2'h0 : eref_cnt + 2'h1;
		if (eref_cnt == 2'h2)
			ext_ref_clock_in <= ~ext_ref_clock_in;
	end
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// ****
	// tasks
	// ****
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 40);
		if (pready_out !== 1'b1)
			n_mismatch++;
		rdat = prdata_out;
		rerr = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	// first edge skipped: the done copy lags the clearing write
	task automatic wait_done(input int lim);
		waited = 0;
		do begin
			@(posedge clk_in);
			waited++;
		end while (conv_done_out !== 1'b1 && waited < lim);
	endtask
	function automatic logic [20:0] route(input logic [4:0] c);
		logic [15:0] e;
		e = (c < 5'h10) ? (16'h1 << c[3:0]) : 16'h0;
		return {e, (c >= 5'h10 && c <= 5'h15) || c == 5'h1e,
			c == 5'h1d, c == 5'h1a, c == 5'h1b, c != 5'h1f};
	endfunction

	// ****
	// sequence
	// ****
	initial begin
		clk_in = 1'b0;
		reset_in = 1'b1;
		{psel_in, penable_in, pwrite_in, wait_mode_in} = 4'h0;
		{ext_ref_clock_in, partial_power_stop_in} = 2'h0;
		{paddr_in, pwdata_in} = 40'h0;
		analog_result_in = 10'h000;
		eref_cnt = 2'h0;
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		chk({31'h0, conv_power_out}, 32'h0);
		rdc(SC, 32'h1f);
		rdc(ST, 32'h0);
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		chk(rdat, 32'h0);
		wr(P1, 32'ha5);
		wr(P2, 32'hffffff3c);
		@(posedge clk_in);
		chk({16'h0, pin_analog_en_out}, 32'h3ca5);
		rdc(P2, 32'h3c);
		// bandgap buffer assumed enabled before code 27 is chosen
		for (int c = 0; c < 32; c++) begin
			wr(SC, 32'(c));
			@(posedge clk_in);
			chk({11'h0, sel_obs}, {11'h0, route(5'(c))});
		end
		// every clock source paired with a different divide
		for (int s = 0; s < 4; s++) begin
			wait_mode_in <= (s == 2);
			analog_result_in <= 10'h2a0 + 10'(s);
			wr(CF, 32'(s) | (32'(s) << 5));
			wr(SC, 32'h3);
			wait_done(3000);
			chk({31'h0, conv_done_out}, 32'h1);
			rdc(RS, 32'h2a0 + 32'(s));
			rdc(SC, 32'h83);
		end
		wait_mode_in <= 1'b0;
		analog_result_in <= 10'h3ff;
		wr(CF, 32'h0);
		wr(SC, 32'h12);
		wait_done(500);
		rdc(RS, 32'h0);
		// stop entry assumes the low-voltage detect bits already set
		partial_power_stop_in <= 1'b1;
		wr(CF, 32'h2);
		wr(SC, 32'h3);
		wait_done(600);
		chk({31'h0, conv_done_out}, 32'h0);
		partial_power_stop_in <= 1'b0;
		wr(SC, 32'h1f);
		@(posedge clk_in);
		chk({31'h0, conv_power_out}, 32'h0);
		wr(CF, 32'h63);
		wr(SC, 32'h3);
		repeat (20) @(posedge clk_in);
		wr(SC, 32'h4);
		wait_done(1000);
		rdc(SC, 32'h84);
		wr(SC, 32'h3);
		repeat (20) @(posedge clk_in);
		wr(SC, 32'h1f);
		wait_done(400);
		chk({31'h0, conv_done_out}, 32'h0);
		rdc(ST, 32'h0);
		wr(CF, 32'h0);
		wr(SC, 32'h23);
		wait_done(500);
		wr(SC, 32'h3f);
		wait_done(300);
		chk({31'h0, conv_done_out | conv_busy_out}, 32'h0);
		// one overflow is 16 ticks of 20 cycles; triggers every other
		wr(CF, 32'h4);
		wr(WK, 32'h1);
		wr(SC, 32'h5);
		wait_done(1200);
		chk({31'h0, conv_done_out}, 32'h1);
		wr(SC, 32'h5);
		wait_done(1200);
		chk({31'h0, waited > 560 && waited < 700}, 32'h1);
		wr(WK, 32'h9);
		wr(SC, 32'h5);
		wait_done(1000);
		chk({31'h0, conv_done_out}, 32'h1);
		partial_power_stop_in <= 1'b1;
		wr(SC, 32'h5);
		wait_done(800);
		chk({31'h0, conv_done_out}, 32'h0);
		tally_and_finish();
	end
endmodule
